/* File: logic/tcr_pkg.sv */
// Package for the 16-bit compare/reload timer: register map, field positions, timing.
// Assumes an Avalon-MM slave with 32-bit data and word-aligned byte addresses.
package tcr_pkg;
    localparam int TCR_NCH = 4;
    localparam int TCR_AW = 6;
    // Register byte addresses
    localparam logic [5:0] TCR_CTRL = 6'h00;
    localparam logic [5:0] TCR_COUNT = 6'h04;
    localparam logic [5:0] TCR_RELOAD = 6'h08;
    localparam logic [5:0] TCR_STATUS = 6'h0c;
    localparam logic [5:0] TCR_MASK = 6'h10;
    localparam logic [5:0] TCR_PORT = 6'h14;
    localparam logic [5:0] TCR_CC0 = 6'h20;
    // Control field positions
    localparam int TCR_F_INSEL = 0;   // 2 bits: 0 stop, 1 timer, 2 event, 3 gated
    localparam int TCR_F_PRESC = 2;   // 1: divide by 24
    localparam int TCR_F_RLD = 3;     // 2 bits: 0 none, 2 mode 0, 3 mode 1
    localparam int TCR_F_EXEN = 5;
    localparam int TCR_F_CMODE = 8;   // 4 bits, one per channel: 0 mode 0, 1 mode 1
    localparam int TCR_F_CEN = 12;    // 4 bits compare enable
    localparam int TCR_F_CAPEN = 16;  // 4 bits capture enable
    localparam int TCR_F_CAPEDGE = 20;// 4 bits: 1 rising, 0 falling
    // Status bit positions
    localparam int TCR_S_OVF = 0;
    localparam int TCR_S_EXR = 1;
    localparam int TCR_S_CMP = 2;     // 4 bits
    localparam int TCR_SW = 6;
    localparam logic [31:0] TCR_CTRL_RST = 32'h0000_0000;
    localparam logic [5:0] TCR_STATUS_RST = 6'h00;
    // Oscillator periods per machine cycle; clk counts as the oscillator
    localparam int TCR_OSC_PER_MC = 12;
    localparam logic [3:0] TCR_MC_LAST = 4'(TCR_OSC_PER_MC - 1);
    typedef enum logic [1:0] {TCR_IN_STOP, TCR_IN_TIMER, TCR_IN_EVENT, TCR_IN_GATED} tcr_insel_t;
endpackage

/* File: logic/tcr_mcgen.sv */
// Machine-cycle and prescaled count enable generator.
// Assumes clk is the oscillator clock; all outputs are one-cycle pulses.
`timescale 1ns/100ps
module tcr_mcgen
    import tcr_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic div24,
    output logic mc_tick,
    output logic rate_tick
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic half;
    logic next_half;
    logic next_mc;
    logic next_rate;

    always_comb
    begin
        next_mc = (cnt == TCR_MC_LAST);
        next_cnt = next_mc ? 4'h0 : cnt + 4'h1;
        next_half = next_mc ? ~half : half;
        next_rate = next_mc & (~div24 | half);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= 4'h0;
            half <= 1'b0;
            mc_tick <= 1'b0;
            rate_tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            half <= next_half;
            mc_tick <= next_mc;
            rate_tick <= next_rate;
        end
    end
endmodule

/* File: logic/tcr_pinsamp.sv */
// Machine-cycle sampler for one external pin with falling and rising detection.
// Assumes the pin is synchronous to clk and holds each level one machine cycle.
`timescale 1ns/100ps
module tcr_pinsamp
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mc_tick,
    input wire logic pin,
    output logic level,
    output logic fall,
    output logic rise
);
    logic next_level;

    always_comb
    begin
        next_level = mc_tick ? pin : level;
    end

    // One-sample-then-zero-sample: detection takes two machine cycles
    assign fall = mc_tick & level & ~pin;
    assign rise = mc_tick & ~level & pin;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            level <= 1'b0;
        end
        else
        begin
            level <= next_level;
        end
    end
endmodule

/* File: logic/tcr_timer.sv */
// Top of the 16-bit compare/capture/reload timer with Avalon-MM register slave.
// Assumes clk is the oscillator clock and all pins are synchronous to it.
`timescale 1ns/100ps
// Behaviour
// - The 16-bit counter sets the overflow flag when it rolls from all ones to zero.
// - Timer function counts at one twelfth or one twenty-fourth of the oscillator rate.
// - Gated function counts the internal rate only while the gate input is high.
// - Gated function samples the gate level once per machine cycle.
// - Event function counts a one sample followed by a zero sample, at most fosc/24.
// - Reload mode 0 sets the overflow flag and loads the reload value on rollover.
// - Reload mode 1 loads the reload value on a falling edge of the reload trigger.
// - The external reload flag is set on that edge only when its enable bit is set.
// - Each compare register is compared with the counter and drives its output on match.
// - Compare mode 0 drives the output high on match and low on overflow.
// - In compare mode 0 software writes to the port latch are ignored.
// - Compare mode 1 copies a software shadow latch to the output on match.
// - Four compare channels give 16-bit PWM and may act as capture inputs.
module tcr_timer
    import tcr_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic gate_count_input,
    input wire logic reload_trigger_input,
    input wire logic [3:0] cc_in,
    output logic [3:0] cmp_out,
    output logic irq
);
    logic mc_tick;
    logic rate_tick;
    logic gate_lvl;
    logic gate_fall;
    logic rld_fall;
    logic [3:0] cap_lvl;
    logic [3:0] cap_fall;
    logic [3:0] cap_rise;

    logic [31:0] timer_control_reg;
    logic [15:0] count;
    logic [15:0] reload;
    logic [TCR_SW-1:0] interrupt_request_reg;
    logic [TCR_SW-1:0] mask;
    logic [3:0] shadow;
    logic [15:0] cc [TCR_NCH];
    logic ack;
    logic [31:0] next_ctrl;
    logic [15:0] next_count;
    logic [15:0] next_reload;
    logic [TCR_SW-1:0] next_status;
    logic [TCR_SW-1:0] next_mask;
    logic [3:0] next_shadow;
    logic [3:0] next_out;
    logic [15:0] next_cc [TCR_NCH];
    logic [31:0] next_rdata;
    logic next_ack;
    logic next_wait;
    logic next_irq;

    tcr_mcgen u_mc
    (
        .clk(clk),
        .arst_n(arst_n),
        .div24(timer_control_reg[TCR_F_PRESC]),
        .mc_tick(mc_tick),
        .rate_tick(rate_tick)
    );

    tcr_pinsamp u_gate
    (
        .clk(clk),
        .arst_n(arst_n),
        .mc_tick(mc_tick),
        .pin(gate_count_input),
        .level(gate_lvl),
        .fall(gate_fall),
        .rise()
    );

    tcr_pinsamp u_rld
    (
        .clk(clk),
        .arst_n(arst_n),
        .mc_tick(mc_tick),
        .pin(reload_trigger_input),
        .level(),
        .fall(rld_fall),
        .rise()
    );

    genvar g;
    generate
        for (g = 0; g < TCR_NCH; g++)
        begin : g_cap
            tcr_pinsamp u_cap
            (
                .clk(clk),
                .arst_n(arst_n),
                .mc_tick(mc_tick),
                .pin(cc_in[g]),
                .level(cap_lvl[g]),
                .fall(cap_fall[g]),
                .rise(cap_rise[g])
            );
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[b*8 +: 8] = wd[b*8 +: 8];
        return r;
    endfunction

    tcr_insel_t insel;
    logic inc;
    logic ovf;
    logic wr;
    logic rd;
    logic [3:0] match;
    logic [1:0] rmode;
    assign insel = tcr_insel_t'(timer_control_reg[TCR_F_INSEL +: 2]);
    assign rmode = timer_control_reg[TCR_F_RLD +: 2];
    // Writes commit on the edge at which the master sees waitrequest low
    assign wr = avs_write & ack;
    assign rd = avs_read & ~ack;

    always_comb
    begin
        case (insel)
            TCR_IN_TIMER: inc = rate_tick;
            TCR_IN_GATED: inc = rate_tick & gate_lvl;
            TCR_IN_EVENT: inc = gate_fall;
            TCR_IN_STOP: inc = 1'b0;
            default: inc = 1'b0;
        endcase
        ovf = inc & (count == 16'hffff);
        for (int i = 0; i < TCR_NCH; i++)
            match[i] = timer_control_reg[TCR_F_CEN + i] & (cc[i] == count);
    end

    always_comb
    begin
        next_ctrl = timer_control_reg;
        next_count = count;
        next_reload = reload;
        next_mask = mask;
        next_shadow = shadow;
        next_out = cmp_out;
        for (int i = 0; i < TCR_NCH; i++)
            next_cc[i] = cc[i];
        next_status = interrupt_request_reg;
        next_rdata = 32'h0000_0000;
        next_ack = (avs_read | avs_write) & ~ack;
        // One wait state per access: waitrequest is low only in the answer cycle
        next_wait = ~next_ack;
        // Software first so hardware events below win over clears and writes, except the count increment
        if (wr)
        begin
            case (avs_address)
                TCR_CTRL: next_ctrl = merge(timer_control_reg, avs_writedata, avs_byteenable);
                TCR_COUNT: next_count = 16'(merge({16'h0000, count}, avs_writedata,
                                                  avs_byteenable));
                TCR_RELOAD: next_reload = 16'(merge({16'h0000, reload}, avs_writedata,
                                                    avs_byteenable));
                TCR_STATUS: if (avs_byteenable[0])
                    next_status = interrupt_request_reg & ~avs_writedata[TCR_SW-1:0];
                TCR_MASK: if (avs_byteenable[0])
                    next_mask = avs_writedata[TCR_SW-1:0];
                TCR_PORT: if (avs_byteenable[0])
                begin
                    for (int i = 0; i < TCR_NCH; i++)
                        if (timer_control_reg[TCR_F_CMODE + i])
                            next_shadow[i] = avs_writedata[i];
                    // Mode 0 channels ignore the write
                end
                default:
                begin
                    for (int i = 0; i < TCR_NCH; i++)
                        if (avs_address == TCR_CC0 + 6'(4 * i))
                            next_cc[i] = 16'(merge({16'h0000, cc[i]}, avs_writedata,
                                                   avs_byteenable));
                end
            endcase
        end
        if (rd)
        begin
            case (avs_address)
                TCR_CTRL: next_rdata = timer_control_reg;
                TCR_COUNT: next_rdata = {16'h0000, count};
                TCR_RELOAD: next_rdata = {16'h0000, reload};
                TCR_STATUS: next_rdata = {26'h0, interrupt_request_reg};
                TCR_MASK: next_rdata = {26'h0, mask};
                TCR_PORT: next_rdata = {20'h0, cap_lvl, shadow, cmp_out};
                default:
                begin
                    for (int i = 0; i < TCR_NCH; i++)
                        if (avs_address == TCR_CC0 + 6'(4 * i))
                            next_rdata = {16'h0000, cc[i]};
                end
            endcase
        end
        // A software count write beats the tick that lands on the same edge
        if (inc && !(wr && avs_address == TCR_COUNT))
            next_count = count + 16'h0001;
        if (ovf)
        begin
            next_status[TCR_S_OVF] = 1'b1;
            if (rmode == 2'b10)
                next_count = reload;
        end
        if (rld_fall && rmode == 2'b11)
            next_count = reload;
        if (rld_fall && timer_control_reg[TCR_F_EXEN])
            next_status[TCR_S_EXR] = 1'b1;
        for (int i = 0; i < TCR_NCH; i++)
        begin
            if (timer_control_reg[TCR_F_CAPEN + i])
            begin
                if (timer_control_reg[TCR_F_CAPEDGE + i] ? cap_rise[i] : cap_fall[i])
                begin
                    next_cc[i] = count;
                    next_status[TCR_S_CMP + i] = 1'b1;
                end
            end
            else if (timer_control_reg[TCR_F_CMODE + i])
            begin
                if (match[i])
                begin
                    next_out[i] = shadow[i];
                    next_status[TCR_S_CMP + i] = 1'b1;
                end
            end
            else
            begin
                // Match wins when both land on the same edge
                if (ovf)
                    next_out[i] = 1'b0;
                if (match[i])
                begin
                    next_out[i] = 1'b1;
                    next_status[TCR_S_CMP + i] = 1'b1;
                end
            end
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timer_control_reg <= TCR_CTRL_RST;
            count <= 16'h0000;
            reload <= 16'h0000;
            interrupt_request_reg <= TCR_STATUS_RST;
            mask <= TCR_STATUS_RST;
            shadow <= 4'h0;
            cmp_out <= 4'h0;
            for (int i = 0; i < TCR_NCH; i++)
                cc[i] <= 16'h0000;
            ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            irq <= 1'b0;
        end
        else
        begin
            timer_control_reg <= next_ctrl;
            count <= next_count;
            reload <= next_reload;
            interrupt_request_reg <= next_status;
            mask <= next_mask;
            shadow <= next_shadow;
            cmp_out <= next_out;
            for (int i = 0; i < TCR_NCH; i++)
                cc[i] <= next_cc[i];
            ack <= next_ack;
            avs_waitrequest <= next_wait;
            avs_readdata <= next_rdata;
            irq <= next_irq;
        end
    end

    a_ovf_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
        ovf |=> interrupt_request_reg[TCR_S_OVF]) else $error("overflow flag not set");
    a_reload_m0: assert property (@(posedge clk) disable iff (!arst_n)
        ovf && rmode == 2'b10 && !rld_fall |=> count == $past(reload))
        else $error("mode 0 reload missed");
    a_reload_m1: assert property (@(posedge clk) disable iff (!arst_n)
        rld_fall && rmode == 2'b11 |=> count == $past(reload))
        else $error("mode 1 reload missed");
    a_exr_gate: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(interrupt_request_reg[TCR_S_EXR])
        |-> $past(rld_fall) && $past(timer_control_reg[TCR_F_EXEN]))
        else $error("reload flag set without enable");
    a_gate_halt: assert property (@(posedge clk) disable iff (!arst_n)
        insel == TCR_IN_GATED && !gate_lvl && !wr && !rld_fall |=> count == $past(count))
        else $error("count moved with gate low");
    a_event_rate: assert property (@(posedge clk) disable iff (!arst_n)
        insel == TCR_IN_EVENT && inc |=> !inc [*8])
        else $error("event count too fast");
    a_cm0_match: assert property (@(posedge clk) disable iff (!arst_n)
        match[0] && !timer_control_reg[TCR_F_CMODE] && !timer_control_reg[TCR_F_CAPEN]
        |=> cmp_out[0]) else $error("mode 0 output not high on match");
    a_cm1_copy: assert property (@(posedge clk) disable iff (!arst_n)
        match[0] && timer_control_reg[TCR_F_CMODE] && !timer_control_reg[TCR_F_CAPEN]
        |=> cmp_out[0] == $past(shadow[0])) else $error("mode 1 shadow not copied");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        interrupt_request_reg[TCR_S_OVF] && !(wr && avs_address == TCR_STATUS)
        |=> interrupt_request_reg[TCR_S_OVF]) else $error("overflow flag lost");
endmodule

/* File: bench/tcr_pin_model.sv */
// Pin-side partner of the timer: gate/count input, reload trigger and capture pins.
// Assumes clk is the oscillator clock; pins change only just after a rising edge.
`timescale 1ns/100ps
module tcr_pin_model
    import tcr_pkg::*;
(
    input wire logic clk,
    output logic gate_count_input,
    output logic reload_trigger_input,
    output logic [3:0] cc_in
);
    initial
    begin
        gate_count_input = 1'b0;
        reload_trigger_input = 1'b1;
        cc_in = 4'h0;
    end

    // A level stands whole machine cycles, so the sampler sees it exactly once per cycle
    task automatic gate_hold(input logic lvl, input int mcs);
        @(posedge clk);
        gate_count_input <= lvl;
        repeat (mcs * TCR_OSC_PER_MC - 1) @(posedge clk);
    endtask

    task automatic reload_fall();
        @(posedge clk);
        reload_trigger_input <= 1'b0;
        repeat (2 * TCR_OSC_PER_MC) @(posedge clk);
        reload_trigger_input <= 1'b1;
        repeat (2 * TCR_OSC_PER_MC) @(posedge clk);
    endtask

    task automatic cap_rise(input int ch);
        @(posedge clk);
        cc_in[ch] <= 1'b1;
        repeat (2 * TCR_OSC_PER_MC) @(posedge clk);
        cc_in[ch] <= 1'b0;
    endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the compare/reload timer, driven over Avalon-MM.
// Assumes the pin model stands on the far side and one wait state per access.
`timescale 1ns/100ps
module tb_top
    import tcr_pkg::*;
;
    logic clk;
    logic arst_n;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic gate_count_input;
    logic reload_trigger_input;
    logic [3:0] cc_in;
    logic [3:0] cmp_out;
    logic irq;
    int n_errors = 0;
    int checks = 0;

    tcr_timer dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gate_count_input(gate_count_input),
        .reload_trigger_input(reload_trigger_input), .cc_in(cc_in),
        .cmp_out(cmp_out), .irq(irq));
    tcr_pin_model pins (.clk(clk), .gate_count_input(gate_count_input),
        .reload_trigger_input(reload_trigger_input), .cc_in(cc_in));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic rd_in(input logic [5:0] a, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] q;
        rd(a, q);
        chk(32'(q >= lo && q <= hi), 32'h1);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        rd(TCR_CTRL, q);
        chk(q, TCR_CTRL_RST);
        rd(TCR_STATUS, q);
        chk(q, 32'(TCR_STATUS_RST));
        rd(6'h3c, q);
        chk(q, 32'h0);
        chk(32'({cmp_out, irq}), 32'h0);
    endtask

    task automatic t_overflow();
        logic [31:0] q;
        wr(TCR_RELOAD, 32'h1234);
        wr(TCR_MASK, 32'h1);
        wr(TCR_COUNT, 32'hfffd);
        wr(TCR_CTRL, 32'h11);
        repeat (72) @(posedge clk);
        rd_in(TCR_COUNT, 32'h1234, 32'h1238);
        repeat (120) @(posedge clk);
        rd(TCR_STATUS, q);
        chk(32'(q[TCR_S_OVF]), 32'h1);
        chk(32'(irq), 32'h1);
        wr(TCR_STATUS, 32'h1);
        rd(TCR_STATUS, q);
        chk(32'(q[TCR_S_OVF]), 32'h0);
        chk(32'(irq), 32'h0);
        rd_in(TCR_COUNT, 32'h1238, 32'h1250);
    endtask

    // 240 clocks between sample edges hold exactly 20 or 10 count ticks
    task automatic t_rate();
        logic [31:0] c1;
        logic [31:0] c2;
        for (int d = 0; d < 2; d++)
        begin
            wr(TCR_CTRL, 32'h0);
            wr(TCR_COUNT, 32'h0);
            wr(TCR_CTRL, 32'h1 | 32'(d << TCR_F_PRESC));
            rd(TCR_COUNT, c1);
            repeat (237) @(posedge clk);
            rd(TCR_COUNT, c2);
            chk(c2 - c1, d ? 32'd10 : 32'd20);
        end
    endtask

    task automatic t_event_gated();
        logic [31:0] c1;
        logic [31:0] c2;
        wr(TCR_CTRL, 32'h0);
        wr(TCR_COUNT, 32'h0);
        wr(TCR_CTRL, 32'h2);
        for (int i = 0; i < 5; i++)
        begin
            pins.gate_hold(1'b1, i + 1);
            pins.gate_hold(1'b0, 1);
        end
        repeat (24) @(posedge clk);
        rd(TCR_COUNT, c1);
        chk(c1, 32'd5);
        wr(TCR_CTRL, 32'h0);
        wr(TCR_COUNT, 32'h0);
        wr(TCR_CTRL, 32'h3);
        repeat (240) @(posedge clk);
        rd(TCR_COUNT, c1);
        chk(c1, 32'h0);
        pins.gate_hold(1'b1, 20);
        pins.gate_hold(1'b0, 1);
        rd_in(TCR_COUNT, 32'd19, 32'd21);
        rd(TCR_COUNT, c1);
        repeat (240) @(posedge clk);
        rd(TCR_COUNT, c2);
        chk(c2, c1);
    endtask

    task automatic t_reload();
        logic [31:0] q;
        wr(TCR_CTRL, 32'h0);
        wr(TCR_RELOAD, 32'habcd);
        for (int e = 0; e < 2; e++)
        begin
            wr(TCR_COUNT, 32'h0);
            wr(TCR_STATUS, 32'h3);
            wr(TCR_CTRL, 32'h1a | 32'(e << TCR_F_EXEN));
            pins.reload_fall();
            rd(TCR_COUNT, q);
            chk(q, 32'habcd);
            rd(TCR_STATUS, q);
            chk(32'(q[TCR_S_EXR]), 32'(e));
        end
    endtask

    task automatic t_compare();
        logic [31:0] q;
        wr(TCR_CTRL, 32'h0);
        wr(TCR_COUNT, 32'h0);
        wr(TCR_STATUS, 32'h3f);
        for (int i = 0; i < TCR_NCH; i++)
            wr(TCR_CC0 + 6'(4 * i), 32'(4 * (i + 1)));
        wr(TCR_CTRL, 32'hf001);
        repeat (300) @(posedge clk);
        chk(32'(cmp_out), 32'hf);
        wr(TCR_PORT, 32'h0);
        chk(32'(cmp_out), 32'hf);
        rd(TCR_STATUS, q);
        chk(32'(q[5:2]), 32'hf);
        wr(TCR_COUNT, 32'hfffe);
        repeat (26) @(posedge clk);
        chk(32'(cmp_out), 32'h0);
        wr(TCR_CTRL, 32'h0);
        wr(TCR_COUNT, 32'h0);
        wr(TCR_CC0, 32'h20);
        wr(TCR_CTRL, 32'h1101);
        wr(TCR_PORT, 32'h1);
        chk(32'(cmp_out[0]), 32'h0);
        repeat (480) @(posedge clk);
        chk(32'(cmp_out[0]), 32'h1);
    endtask

    // Counter stopped so the captured value is known exactly
    task automatic t_capture();
        logic [31:0] q;
        wr(TCR_CTRL, 32'h0);
        wr(TCR_COUNT, 32'h0100);
        wr(TCR_CTRL, 32'h220000);
        pins.cap_rise(1);
        repeat (24) @(posedge clk);
        rd(TCR_CC0 + 6'h4, q);
        chk(q, 32'h0100);
        // Running timer: a falling capture lands 2..3 ticks in, a rising one 0..1
        wr(TCR_COUNT, 32'h0);
        wr(TCR_CTRL, 32'h40001);
        pins.cap_rise(2);
        repeat (24) @(posedge clk);
        rd_in(TCR_CC0 + 6'h8, 32'd2, 32'd3);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        arst_n = 1'b0;
        avs_address = 6'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_overflow();
        t_rate();
        t_event_gated();
        t_reload();
        t_compare();
        t_capture();
        report_and_stop();
    end
endmodule
